// File: logic/ohp_tx_oh_port.sv
// Purpose: transmit overhead insert port, one channel
// Assumes: frame generator events arrive as single-cycle pulses on i_clk_sys,
//          far apart compared with the port clock period
// Notes:   port-side logic runs on the falling edge of the port clock
`timescale 1ns/100ps
module ohp_tx_oh_port import ohp_pkg::*; (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_srst,
  input  wire logic                  i_mode_sts1,
  input  wire logic                  i_toh_ext,
  input  wire logic                  i_ev_first_oh,
  input  wire logic                  i_ev_a1,
  input  wire logic                  i_ev_j1,
  input  wire logic                  i_oh_ready,
  output logic                       o_oh_valid,
  output logic [OHP_WORD_W-1:0]      o_oh_data,
  output logic                       o_overrun,
  input  wire logic                  i_overhead_port_clock,
  input  wire logic                  i_overhead_insert_request,
  input  wire logic                  i_overhead_serial_input,
  output logic                       o_overhead_frame_pulse,
  output logic                       o_overhead_window_indicator
);

  // system clock state
  typedef struct packed {
    logic [2:0]            ev_tog;    // {j1, a1, first_oh} event toggles
    logic [1:0]            req_s;     // byte-ready toggle from port side
    logic                  ack_tog;   // byte taken into the fifo
    logic                  push_v;
    logic [OHP_WORD_W-1:0] push_d;
    logic [1:0]            ovr_s;
    logic                  ovr_prev;
    logic                  overrun;
  } ohp_sys_st_t;

  // port clock state
  typedef struct packed {
    logic [1:0]            rst_s;
    logic [1:0]            sts_s;
    logic [1:0]            toh_s;
    logic [2:0]            ev_s1;
    logic [2:0]            ev_s2;
    logic [2:0]            ev_prev;
    logic [1:0]            ack_s;
    logic                  frame;
    logic                  win;
    logic [OHP_WORD_W-1:0] shreg;
    logic [2:0]            bitcnt;
    logic                  tx_tog;
    logic [OHP_WORD_W-1:0] tx_data;
    logic                  ovr_tog;
  } ohp_lnk_st_t;

  ohp_sys_st_t sq;
  ohp_sys_st_t sd;
  ohp_lnk_st_t lq;
  ohp_lnk_st_t ld;

  logic       lrst;
  logic       sts;
  logic       toh;
  logic [2:0] ev;
  logic       fo_hit;
  logic       a1_hit;
  logic       j1_hit;
  logic       busy;
  logic       byte_done;
  logic       pend;

  ohp_stream_if #(.W(OHP_WORD_W)) fs ();

  ohp_fifo #(
    .WIDTH (OHP_WORD_W),
    .DEPTH (OHP_FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .s         (fs)
  );

  // fifo fill from the handshake hold register, drain to the frame generator
  assign fs.push_valid = sq.push_v;
  assign fs.push_data  = sq.push_d;
  assign fs.pop_ready  = i_oh_ready;

  // port side decode; only second-stage sync flops are looked at
  assign lrst      = lq.rst_s[1];
  assign sts       = lq.sts_s[1];
  assign toh       = lq.toh_s[1];
  assign ev        = lq.ev_s2 ^ lq.ev_prev;
  assign fo_hit    = !sts && ev[0];
  assign a1_hit    = sts && toh && ev[1];
  assign j1_hit    = sts && ev[2];
  assign busy      = (lq.tx_tog != lq.ack_s[1]);
  assign byte_done = i_overhead_insert_request && (lq.bitcnt == OHP_LAST_BIT);

  // port clock next state; reset is applied synchronously once synced over
  always_comb begin
    ld         = lq;
    ld.rst_s   = {lq.rst_s[0], i_srst};
    ld.sts_s   = {lq.sts_s[0], i_mode_sts1};
    ld.toh_s   = {lq.toh_s[0], i_toh_ext};
    ld.ev_s1   = sq.ev_tog;
    ld.ev_s2   = lq.ev_s1;
    ld.ev_prev = lq.ev_s2;
    ld.ack_s   = {lq.ack_s[0], sq.ack_tog};
    // each qualified event gives a pulse of exactly one port period
    ld.frame   = fo_hit || a1_hit || j1_hit;
    // window tells which overhead the pulse opens
    if (j1_hit) begin
      ld.win = 1'b1;
    end else if (a1_hit || fo_hit) begin
      ld.win = 1'b0;
    end
    if (!sts) begin
      ld.win = 1'b0;
    end
    // bits are taken on the falling edge, midway in the far end's bit time
    if (i_overhead_insert_request) begin
      ld.shreg  = {lq.shreg[OHP_WORD_W-2:0], i_overhead_serial_input};
      ld.bitcnt = lq.bitcnt + 3'h1;
      if (byte_done) begin
        // no stall toward the far end is possible, so a full path drops the byte
        if (!busy) begin
          ld.tx_tog  = !lq.tx_tog;
          ld.tx_data = {lq.shreg[OHP_WORD_W-2:0], i_overhead_serial_input};
        end else begin
          ld.ovr_tog = !lq.ovr_tog;
        end
      end
    end
    if (lrst) begin
      ld.ev_prev = lq.ev_s2;                          // no stale edge out of reset
      ld.frame   = 1'b0;
      ld.win     = 1'b0;
      ld.shreg   = OHP_BYTE_RST;
      ld.bitcnt  = OHP_BIT_RST;
      ld.tx_tog  = 1'b0;
      ld.tx_data = OHP_BYTE_RST;
      ld.ovr_tog = 1'b0;
    end
  end

  always_ff @(negedge i_overhead_port_clock) begin
    lq <= ld;
  end

  // system clock next state: event toggles out, bytes in through the fifo
  always_comb begin
    sd          = sq;
    sd.ev_tog   = sq.ev_tog ^ {i_ev_j1, i_ev_a1, i_ev_first_oh};
    sd.req_s    = {sq.req_s[0], lq.tx_tog};
    sd.ovr_s    = {sq.ovr_s[0], lq.ovr_tog};
    sd.ovr_prev = sq.ovr_s[1];
    if (sq.ovr_s[1] != sq.ovr_prev) begin
      sd.overrun = 1'b1;
    end
    pend = (sq.req_s[1] != sq.ack_tog);
    // ack only once the fifo took the byte, so a full fifo holds off the port
    if (sq.push_v) begin
      if (fs.push_ready) begin
        sd.push_v  = 1'b0;
        sd.ack_tog = !sq.ack_tog;
      end
    end else if (pend) begin
      sd.push_v = 1'b1;
      sd.push_d = lq.tx_data;                         // held stable until acked
    end
    if (i_srst) begin
      sd = '0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    sq <= sd;
  end

  assign o_overhead_frame_pulse      = lq.frame;
  assign o_overhead_window_indicator = lq.win;
  assign o_oh_valid                  = fs.pop_valid;
  assign o_oh_data                   = fs.pop_data;
  assign o_overrun                   = sq.overrun;

  pulse_width_a: assert property (@(negedge i_overhead_port_clock) disable iff (lrst)
    o_overhead_frame_pulse && !ev[0] && !ev[1] && !ev[2] |=> !o_overhead_frame_pulse)
    else $error("frame pulse longer than one port period");
  ds3_pulse_a: assert property (@(negedge i_overhead_port_clock) disable iff (lrst)
    fo_hit |=> o_overhead_frame_pulse && !o_overhead_window_indicator)
    else $error("first overhead bit event gave no frame pulse");
  a1_window_a: assert property (@(negedge i_overhead_port_clock) disable iff (lrst)
    a1_hit && !j1_hit |=> o_overhead_frame_pulse && !o_overhead_window_indicator)
    else $error("A1 pulse without window low");
  j1_window_a: assert property (@(negedge i_overhead_port_clock) disable iff (lrst)
    j1_hit |=> o_overhead_frame_pulse && o_overhead_window_indicator)
    else $error("J1 pulse without window high");
  poh_only_a: assert property (@(negedge i_overhead_port_clock) disable iff (lrst)
    sts && !toh && !ev[2] |=> !o_overhead_frame_pulse)
    else $error("pulse without J1 event in path-only mode");
  both_oh_a: assert property (@(negedge i_overhead_port_clock) disable iff (lrst)
    sts && toh && ev[1] |=> o_overhead_frame_pulse)
    else $error("A1 event gave no pulse with transport insertion");
  ins_ignore_a: assert property (@(negedge i_overhead_port_clock) disable iff (lrst)
    !i_overhead_insert_request |=> $stable(lq.shreg) && $stable(lq.bitcnt))
    else $error("serial input taken without insert request");
  byte_pass_a: assert property (@(negedge i_overhead_port_clock) disable iff (lrst)
    byte_done && !busy |=> lq.tx_tog != $past(lq.tx_tog) ##1 busy)
    else $error("completed byte not handed over");
  byte_drop_a: assert property (@(negedge i_overhead_port_clock) disable iff (lrst)
    byte_done && busy |=> $stable(lq.tx_tog) && $changed(lq.ovr_tog))
    else $error("byte overran a pending handover unnoticed");
endmodule

// File: logic/ohp_pkg.sv
// Purpose: shared constants for the transmit overhead insert port
// Assumes: one channel per instance; overhead bytes are shifted msb first
// Notes:   widths and depths are fixed; nothing here is tunable per instance
package ohp_pkg;
  localparam int         OHP_WORD_W     = 8;      // one overhead byte per fifo word
  localparam int         OHP_FIFO_DEPTH = 32;     // bytes buffered toward the frame generator
  localparam logic [2:0] OHP_LAST_BIT   = 3'h7;   // bit index that completes a byte
  localparam logic [2:0] OHP_BIT_RST    = 3'h0;   // bit counter after reset
  localparam logic [7:0] OHP_BYTE_RST   = 8'h00;  // shift and hold registers after reset
endpackage

// File: logic/ohp_stream_if.sv
// Purpose: valid/ready byte stream between the port logic and its fifo
// Assumes: both sides on the system clock
// Notes:   fill side is push_*, drain side is pop_*
`timescale 1ns/100ps
interface ohp_stream_if #(parameter int W = 8);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  modport fifo (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
  modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface

// File: logic/ohp_fifo.sv
// Purpose: flop based fifo holding overhead bytes for the frame generator
// Assumes: single clock, synchronous active high reset
// Notes:   pointers carry one wrap bit so full and empty are exact
`timescale 1ns/100ps
module ohp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic  i_clk_sys,
  input  wire logic  i_srst,
  ohp_stream_if.fifo s
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
    logic                        ne;   // registered not-empty, so valid leaves a flop
  } ohp_fifo_st_t;

  ohp_fifo_st_t q;
  ohp_fifo_st_t d;
  logic         full;
  logic         empty;
  logic         push_fire;
  logic         pop_fire;
  logic [AW:0]  level;

  // full when pointers differ only in the wrap bit
  assign full      = (q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]);
  assign empty     = !q.ne;
  assign push_fire = s.push_valid && !full;
  assign pop_fire  = s.pop_ready && !empty;
  assign level     = q.wr - q.rd;

  assign s.push_ready = !full;
  assign s.pop_valid  = q.ne;
  assign s.pop_data   = q.mem[q.rd[AW-1:0]];

  // next state: write at wr, read at rd, both may happen in one cycle
  always_comb begin
    d = q;
    if (push_fire) begin
      d.mem[q.wr[AW-1:0]] = s.push_data;
      d.wr                = q.wr + 1'b1;
    end
    if (pop_fire) begin
      d.rd = q.rd + 1'b1;
    end
    if (i_srst) begin
      d.wr = '0;
      d.rd = '0;
    end
    // flag follows the next pointers, so it always equals wr != rd
    d.ne = (d.wr != d.rd);
  end

  always_ff @(posedge i_clk_sys) begin
    q <= d;
  end

  fill_visible_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    push_fire && !pop_fire |=> s.pop_valid && !empty)
    else $error("pushed byte not visible on drain side");
  drain_empty_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    pop_fire && !push_fire && (level == 1) |=> !s.pop_valid)
    else $error("fifo not empty after last byte drained");
endmodule

// File: verification/ohp_far_end.sv
// Purpose: far end overhead insertion logic facing the transmit overhead port
// Assumes: port clock runs free; far end launches on rising edges only
// Notes:   counts frame pulses by window state so the bench can compare
`timescale 1ns/100ps
module ohp_far_end (
  input  wire logic i_clk_port,
  input  wire logic i_frame_pulse,
  input  wire logic i_window,
  output logic      o_insert_request,
  output logic      o_serial
);
  logic [7:0] a1_n;
  logic [7:0] j1_n;
  logic [7:0] wide_n;
  logic       prev_q;

  initial begin
    o_insert_request = 1'b0;
    o_serial         = 1'b0;
    a1_n             = 8'h00;
    j1_n             = 8'h00;
    wide_n           = 8'h00;
    prev_q           = 1'b0;
  end

  // sample on rising edge, half a period after the falling-edge launch
  always @(posedge i_clk_port) begin
    if (i_frame_pulse && !i_window) a1_n <= a1_n + 8'h01;
    if (i_frame_pulse && i_window) j1_n <= j1_n + 8'h01;
    if (i_frame_pulse && prev_q) wide_n <= wide_n + 8'h01;
    prev_q <= i_frame_pulse;
  end

  // one byte msb first; gap edges with request low are spliced in before bit 3
  task automatic send_byte(input logic [7:0] b, input int gap);
    for (int i = 7; i >= 0; i--) begin
      if (i == 3) repeat (gap) begin
        @(posedge i_clk_port);
        o_insert_request <= 1'b0;
        o_serial         <= ~o_serial;  // junk the port must ignore
      end
      @(posedge i_clk_port);
      o_insert_request <= 1'b1;
      o_serial         <= b[i];
    end
  endtask

  // drop the request; the data line shows the inverse, not a held value
  task automatic release_line();
    @(posedge i_clk_port);
    o_insert_request <= 1'b0;
    o_serial         <= ~o_serial;
  endtask
endmodule

// File: verification/tb_top.sv
// Purpose: self-checking bench for the transmit overhead insert port
// Assumes: port clock free running at 125 ns, phase unrelated to system clock
// Notes:   a queue of sent bytes is the reference for every popped byte
`timescale 1ns/100ps
module tb_top;
  import ohp_pkg::*;
  logic                  clk, clk_port, srst, sts1, toh, ev_f, ev_a, ev_j, rdy, drain;
  logic                  oh_valid, overrun, fpulse, window, req, ser;
  logic [OHP_WORD_W-1:0] oh_data;
  logic [7:0]            exp_q[$];
  logic [7:0]            a1_0, j1_0, b;
  int                    miscompares, num_checks;

  ohp_tx_oh_port dut (.i_clk_sys(clk), .i_srst(srst), .i_mode_sts1(sts1), .i_toh_ext(toh),
    .i_ev_first_oh(ev_f), .i_ev_a1(ev_a), .i_ev_j1(ev_j), .i_oh_ready(rdy),
    .o_oh_valid(oh_valid), .o_oh_data(oh_data), .o_overrun(overrun),
    .i_overhead_port_clock(clk_port), .i_overhead_insert_request(req),
    .i_overhead_serial_input(ser), .o_overhead_frame_pulse(fpulse),
    .o_overhead_window_indicator(window));
  ohp_far_end far (.i_clk_port(clk_port), .i_frame_pulse(fpulse), .i_window(window),
    .o_insert_request(req), .o_serial(ser));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // odd start offset keeps the two clocks out of step
  initial begin
    clk_port = 1'b0;
    #37;
    forever #62.5 clk_port = ~clk_port;
  end

  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_data({7'h00, got}, {7'h00, exp});
  endtask
  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // drain side with random stalls; every pop is checked against the queue
  always @(posedge clk) begin
    rdy <= drain & 1'($urandom_range(1, 0));
    if (oh_valid === 1'b1 && rdy === 1'b1) begin
      if (exp_q.size() > 0) chk_data(oh_data, exp_q.pop_front());
      else chk_flag(oh_valid, 1'b0);
    end
  end

  // one event pulse, then eight port periods for it to reach the pins
  task automatic fire(input int k, input logic [7:0] da, input logic [7:0] dj);
    a1_0 = far.a1_n;
    j1_0 = far.j1_n;
    @(posedge clk);
    ev_f <= (k == 0);
    ev_a <= (k == 1);
    ev_j <= (k == 2);
    @(posedge clk);
    {ev_f, ev_a, ev_j} <= 3'h0;
    repeat (250) @(posedge clk);
    chk_data(far.a1_n - a1_0, da);
    chk_data(far.j1_n - j1_0, dj);
  endtask
  task automatic send(input int gap, input bit keep);
    b = 8'($urandom);
    far.send_byte(b, gap);
    if (keep) exp_q.push_back(b);
  endtask
  task automatic wait_empty();
    for (int n = 0; n < 4000 && exp_q.size() > 0; n++) @(posedge clk);
    repeat (8) @(posedge clk);
    chk_data(8'(exp_q.size()), 8'h00);
    chk_flag(oh_valid, 1'b0);
  endtask

  initial begin
    void'($urandom(32'h1c7c44dc));
    {srst, sts1, toh, ev_f, ev_a, ev_j, drain} = 7'h40;
    miscompares = 0;
    num_checks  = 0;
    // long enough for the port side to see reset through its synchronizer
    repeat (16) @(posedge clk_port);
    @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(negedge clk_port);
    chk_flag(overrun, 1'b0);
    chk_flag(fpulse, 1'b0);
    chk_flag(window, 1'b0);
    drain <= 1'b1;
    fire(0, 8'h01, 8'h00);
    fire(1, 8'h00, 8'h00);
    fire(2, 8'h00, 8'h00);
    repeat (2) send(0, 1'b1);
    far.release_line();
    wait_empty();
    @(posedge clk);
    sts1 <= 1'b1;
    fire(1, 8'h00, 8'h00);
    fire(2, 8'h00, 8'h01);
    fire(0, 8'h00, 8'h00);
    @(posedge clk);
    toh <= 1'b1;
    fire(1, 8'h01, 8'h00);
    fire(2, 8'h00, 8'h01);
    chk_data(far.wide_n, 8'h00);
    repeat (3) send(2, 1'b1);
    far.release_line();
    wait_empty();
    // fill: fifo plus the crossing stage hold 33, the next byte is dropped
    drain <= 1'b0;
    for (int i = 0; i < 34; i++) begin
      if (i == 33) chk_flag(overrun, 1'b0);
      send(0, i < 33);
    end
    far.release_line();
    repeat (100) @(posedge clk);
    chk_flag(overrun, 1'b1);
    drain <= 1'b1;
    wait_empty();
    end_of_test();
  end

  // watchdog well past the roughly 52 us the sequence needs
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
endmodule
